// ==== logic/rmpc_pkg.sv ====
// Shared constants and types for the receiver mode pin control block.
package rmpc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_MODE     = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;

  localparam int unsigned CTRL_AUTO_BIT = 0;
  localparam logic        CTRL_AUTO_RST = 1'b1;

  localparam int unsigned MODE_VIDEO_BIT   = 0;
  localparam int unsigned MODE_ASI_BIT     = 1;
  localparam int unsigned MODE_THROUGH_BIT = 2;
  localparam int unsigned MODE_LOCK_BIT    = 3;
  localparam int unsigned MODE_CEA_BIT     = 4;
  localparam int unsigned MODE_AUTO_BIT    = 5;

  localparam int unsigned IRQ_W            = 3;
  localparam int unsigned IRQ_MODE_BIT     = 0;
  localparam int unsigned IRQ_LOCK_BIT     = 1;
  localparam int unsigned IRQ_CONFLICT_BIT = 2;
  localparam logic [2:0]  IRQ_MASK_RST     = 3'h0;

  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned PIN_W       = 3;
  localparam int unsigned PIN_LOCK    = 0;
  localparam int unsigned PIN_TRANS   = 1;
  localparam int unsigned PIN_STYLE   = 2;

  typedef enum logic [1:0] {
    MODE_VIDEO,
    MODE_ASI,
    MODE_THROUGH
  } rmpc_mode_e;

endpackage

// ==== logic/rmpc_sync.sv ====
// Two-stage synchroniser for the asynchronous control pins.
`timescale 1ns/100ps
`default_nettype none
module rmpc_sync
#(
  parameter int unsigned WIDTH = 1
)
(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  genvar i;

  generate
    for (i = 0; i < WIDTH; i++)
    begin : gBit
      logic meta_r;
      logic stable_r;

      // The first stage feeds only the second; nothing else may look at it.
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_r   <= 1'b0;
          stable_r <= 1'b0;
        end
        else
        begin
          meta_r   <= asyncIn[i];
          stable_r <= meta_r;
        end
      end

      assign syncOut[i] = stable_r;
    end
  endgenerate

endmodule
`default_nettype wire

// ==== logic/rmpc_top.sv ====
// Operating-mode control of the receiver, driven by pins and registers.
//
// Notes on behaviour
// - Auto mode drives lock pin with lock.
// - Manual mode releases lock pin as input.
// - Manual, lock pin low: no descramble, processing.
// - Manual, lock pin high: descramble and process.
// - Both pins low manual: data-through operation.
// - Manual, lock pin low, transport pin high: transport extraction.
// - Auto mode drives transport pin low, ignored.
// - Style select high: sync/DE timing outputs.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
module rmpc_top
(
  input  wire logic                           mclk,
  input  wire logic                           rst_n,
  input  wire logic [rmpc_pkg::ADDR_W-1:0]    regAddr,
  input  wire logic [rmpc_pkg::DATA_W-1:0]    regWdata,
  input  wire logic                           regWr,
  input  wire logic                           regRd,
  output logic      [rmpc_pkg::DATA_W-1:0]    regRdata,
  output logic                                irq,
  input  wire logic                           lockedToStd,
  input  wire logic                           videoLockModePinIn,
  output logic                                videoLockModePinOut,
  output logic                                videoLockModePinOe,
  input  wire logic                           transportModePinIn,
  output logic                                transportModePinOut,
  output logic                                transportModePinOe,
  input  wire logic                           syncStyleSelect,
  input  wire logic                           flagH,
  input  wire logic                           flagV,
  input  wire logic                           flagF,
  input  wire logic                           ceaHsync,
  input  wire logic                           ceaVsync,
  input  wire logic                           ceaDe,
  output logic      [2:0]                     timingOut,
  output logic                                descrambleEn,
  output logic                                ioProcEn,
  output logic                                asiEn,
  output logic                                dataThroughEn
);

  import rmpc_pkg::*;

  logic [PIN_W-1:0]  pinRaw;
  logic [PIN_W-1:0]  pinSync;
  logic              lockSync;
  logic              transSync;
  logic              styleSync;
  logic              autoMode_r;
  rmpc_mode_e        mode_r;
  rmpc_mode_e        modeNxt;
  logic              lockOut_r;
  logic              lockPrev_r;
  logic [2:0]        timing_r;
  logic [2:0]        timingNxt;
  logic              descramble_r;
  logic              ioProc_r;
  logic              asi_r;
  logic              through_r;
  logic [IRQ_W-1:0]  irqStat_r;
  logic [IRQ_W-1:0]  irqStatNxt;
  logic [IRQ_W-1:0]  irqMask_r;
  logic [IRQ_W-1:0]  irqEvent;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdataNxt;
  logic [DATA_W-1:0] modeWord;
  logic              selCtrl;
  logic              selMode;
  logic              selStat;
  logic              selMask;
  logic              manualConflict;

  // Decodes a manual pin setting; a conflicting request favours video.
  function automatic rmpc_mode_e decodeManual(input logic lock,
                                              input logic trans);
    if (lock)
      return MODE_VIDEO;
    else if (trans)
      return MODE_ASI;
    else
      return MODE_THROUGH;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [7:0]        ofs);
    return addr == ofs;
  endfunction

  assign pinRaw[PIN_LOCK]  = videoLockModePinIn;
  assign pinRaw[PIN_TRANS] = transportModePinIn;
  assign pinRaw[PIN_STYLE] = syncStyleSelect;

  rmpc_sync
  #(
    .WIDTH   (PIN_W)
  )
  uSync
  (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .asyncIn (pinRaw),
    .syncOut (pinSync)
  );

  assign lockSync  = pinSync[PIN_LOCK];
  assign transSync = pinSync[PIN_TRANS];
  assign styleSync = pinSync[PIN_STYLE];

  assign selCtrl = hit(regAddr, OFS_CTRL);
  assign selMode = hit(regAddr, OFS_MODE);
  assign selStat = hit(regAddr, OFS_IRQ_STAT);
  assign selMask = hit(regAddr, OFS_IRQ_MASK);

  assign modeNxt = autoMode_r ? MODE_VIDEO
                              : decodeManual(lockSync, transSync);

  assign manualConflict = !autoMode_r && lockSync && transSync;

  assign timingNxt = styleSync ? {ceaHsync, ceaVsync, ceaDe}
                               : {flagH, flagV, flagF};

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_r       <= MODE_VIDEO;
      descramble_r <= 1'b1;
      ioProc_r     <= 1'b1;
      asi_r        <= 1'b0;
      through_r    <= 1'b0;
    end
    else
    begin
      mode_r       <= modeNxt;
      descramble_r <= modeNxt == MODE_VIDEO;
      ioProc_r     <= modeNxt == MODE_VIDEO;
      asi_r        <= modeNxt == MODE_ASI;
      through_r    <= modeNxt == MODE_THROUGH;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lockOut_r  <= 1'b0;
      lockPrev_r <= 1'b0;
      timing_r   <= 3'h0;
    end
    else
    begin
      lockOut_r  <= lockedToStd;
      lockPrev_r <= lockedToStd;
      timing_r   <= timingNxt;
    end
  end

  assign videoLockModePinOut = lockOut_r;
  assign videoLockModePinOe  = autoMode_r;

  assign transportModePinOut = 1'b0;
  assign transportModePinOe  = autoMode_r;

  assign timingOut     = timing_r;
  assign descrambleEn  = descramble_r;
  assign ioProcEn      = ioProc_r;
  assign asiEn         = asi_r;
  assign dataThroughEn = through_r;

  // Events: a new mode, a lock edge, and an illegal manual request.
  assign irqEvent[IRQ_MODE_BIT]     = modeNxt != mode_r;
  assign irqEvent[IRQ_LOCK_BIT]     = lockedToStd != lockPrev_r;
  assign irqEvent[IRQ_CONFLICT_BIT] = manualConflict;

  // A write of one clears, but an event in the same cycle still sets.
  assign irqStatNxt = (irqStat_r & ~((regWr && selStat)
                                     ? regWdata[IRQ_W-1:0]
                                     : {IRQ_W{1'b0}})) | irqEvent;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      autoMode_r <= CTRL_AUTO_RST;
      irqMask_r  <= IRQ_MASK_RST;
      irqStat_r  <= '0;
    end
    else
    begin
      if (regWr && selCtrl)
        autoMode_r <= regWdata[CTRL_AUTO_BIT];
      if (regWr && selMask)
        irqMask_r <= regWdata[IRQ_W-1:0];
      irqStat_r <= irqStatNxt;
    end
  end

  assign irq = |(irqStat_r & irqMask_r);

  always_comb
  begin
    modeWord                   = '0;
    modeWord[MODE_VIDEO_BIT]   = mode_r == MODE_VIDEO;
    modeWord[MODE_ASI_BIT]     = mode_r == MODE_ASI;
    modeWord[MODE_THROUGH_BIT] = mode_r == MODE_THROUGH;
    modeWord[MODE_LOCK_BIT]    = lockOut_r;
    modeWord[MODE_CEA_BIT]     = styleSync;
    modeWord[MODE_AUTO_BIT]    = autoMode_r;
  end

  // Read data are zero outside the cycle after a read strobe.
  assign rdataNxt = !regRd  ? '0 :
                    selCtrl ? {{(DATA_W-1){1'b0}}, autoMode_r} :
                    selMode ? modeWord :
                    selStat ? {{(DATA_W-IRQ_W){1'b0}}, irqStat_r} :
                    selMask ? {{(DATA_W-IRQ_W){1'b0}}, irqMask_r} :
                              '0;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= '0;
    else
      rdata_r <= rdataNxt;
  end

  assign regRdata = rdata_r;

  chk_lock_drive: assert property (
    @(posedge mclk) disable iff (!rst_n)
    autoMode_r && $past(rst_n) |-> videoLockModePinOe
      && videoLockModePinOut == $past(lockedToStd))
    else $error("Lock pin not driving lock status in auto mode.");

  chk_lock_release: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !autoMode_r |-> !videoLockModePinOe && !transportModePinOe)
    else $error("Lock pin still driven in manual mode.");

  chk_bypass_off: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !autoMode_r && !lockSync |=> !descrambleEn && !ioProcEn)
    else $error("Video processing active with lock pin low.");

  chk_video_on: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !autoMode_r && lockSync |=> descrambleEn && ioProcEn && !asiEn)
    else $error("Video processing missing with lock pin high.");

  chk_through_mode: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !autoMode_r && !lockSync && !transSync |=> dataThroughEn
      && !asiEn && !descrambleEn)
    else $error("Data-through not entered with both pins low.");

  chk_mode_onehot: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $onehot({descrambleEn, asiEn, dataThroughEn})
      && ioProcEn == descrambleEn)
    else $error("Mode enables not exclusive.");

  chk_asi_mode: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !autoMode_r && transSync && !lockSync |=> asiEn
      && !dataThroughEn)
    else $error("Transport extraction not entered.");

  chk_conflict_flag: assert property (
    @(posedge mclk) disable iff (!rst_n)
    manualConflict |=> irqStat_r[IRQ_CONFLICT_BIT])
    else $error("Conflicting manual request not flagged.");

  chk_auto_trans: assert property (
    @(posedge mclk) disable iff (!rst_n)
    autoMode_r |-> transportModePinOe && !transportModePinOut
      ##1 !asiEn)
    else $error("Transport pin or extraction wrong in auto mode.");

  chk_timing_sel: assert property (
    @(posedge mclk) disable iff (!rst_n)
    styleSync |=> timingOut == {$past(ceaHsync), $past(ceaVsync),
                                $past(ceaDe)})
    else $error("Sync/DE timing not selected.");

  chk_timing_flag: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !styleSync |=> timingOut == {$past(flagH), $past(flagV),
                                 $past(flagF)})
    else $error("Flag timing not selected.");

  chk_pin_sync: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $past(rst_n, 2) |-> lockSync == $past(videoLockModePinIn, 2))
    else $error("Lock pin not seen two cycles late.");

  chk_trans_sync: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $past(rst_n, 2) |-> transSync == $past(transportModePinIn, 2))
    else $error("Transport pin not seen two cycles late.");

  chk_irq_level: assert property (
    @(posedge mclk) disable iff (!rst_n)
    irqEvent[IRQ_MODE_BIT] && irqMask_r[IRQ_MODE_BIT] |=> irq)
    else $error("Unmasked mode event did not raise the interrupt.");

  // A one written clears the bit, unless its event comes again.
  chk_stat_clear: assert property (
    @(posedge mclk) disable iff (!rst_n)
    regWr && selStat && regWdata[IRQ_LOCK_BIT]
      && !irqEvent[IRQ_LOCK_BIT] |=> !irqStat_r[IRQ_LOCK_BIT])
    else $error("Lock status bit not cleared by a one.");

  // The event wins over a clear written in the same cycle.
  chk_stat_set: assert property (
    @(posedge mclk) disable iff (!rst_n)
    irqEvent[IRQ_MODE_BIT] |=> irqStat_r[IRQ_MODE_BIT])
    else $error("Mode status bit not set by its event.");

  // Read data stay zero outside the answer cycle.
  chk_rdata_idle: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !$past(regRd) |-> regRdata == '0)
    else $error("Read data not zero outside the answer cycle.");

endmodule
`default_nettype wire

// ==== verification/rmpc_ctrl_model.sv ====
// Behavioural external controller that drives the released mode pins.
`timescale 1ns/100ps
`default_nettype none
module rmpc_ctrl_model
(
  input  wire logic lockOut,
  input  wire logic lockOe,
  input  wire logic transOut,
  input  wire logic transOe,
  input  wire logic reqLock,
  input  wire logic reqTrans,
  input  wire logic allowBoth,
  output logic      lockWire,
  output logic      transWire
);
  logic lockDrv;
  // lock held low while transport is requested.
  // Only a scenario that sets allowBoth may break this on purpose.
  assign lockDrv = reqLock & ~(reqTrans & ~allowBoth);
  // released pins driven.
  // The controller drives a pin only while the device has let it go.
  assign lockWire  = lockOe ? lockOut : lockDrv;
  assign transWire = transOe ? transOut : reqTrans;
endmodule
`default_nettype wire

// ==== verification/tb_receiver_mode_pin_control.sv ====
// Self-checking bench for the receiver mode pin control block.
`timescale 1ns/100ps
`default_nettype none
module tb_receiver_mode_pin_control;
  import rmpc_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d;} rmpc_note_s;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic [31:0] regRdata;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        irq, lockOut, lockOe, transOut, transOe;
  logic        lockWire, transWire, rdSeen;
  logic        lockedToStd = 1'b0;
  logic        reqLock = 1'b1;
  logic        reqTrans = 1'b0;
  logic        allowBoth = 1'b0;
  logic        styleSel = 1'b0;
  logic [5:0]  tIn = 6'h00;
  logic [2:0]  timingOut;
  wire  [3:0]  en;
  rmpc_note_s  q[$];
  rmpc_note_s  note;
  int          checks = 0;
  int          n_mismatch = 0;
  int          cyc = 0;
  logic [1:0]  pinTbl[4] = '{2'h2, 2'h0, 2'h1, 2'h3};
  logic [3:0]  enTbl[4] = '{4'hC, 4'h1, 4'h2, 4'hC};
  logic [31:0] modeTbl[4] = '{32'h01, 32'h04, 32'h02, 32'h01};

  always #12.5 mclk = ~mclk;

  rmpc_top u_dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .irq(irq), .lockedToStd(lockedToStd),
    .videoLockModePinIn(lockWire), .videoLockModePinOut(lockOut),
    .videoLockModePinOe(lockOe), .transportModePinIn(transWire),
    .transportModePinOut(transOut), .transportModePinOe(transOe),
    .syncStyleSelect(styleSel), .flagH(tIn[5]), .flagV(tIn[4]),
    .flagF(tIn[3]), .ceaHsync(tIn[2]), .ceaVsync(tIn[1]),
    .ceaDe(tIn[0]), .timingOut(timingOut), .descrambleEn(en[3]),
    .ioProcEn(en[2]), .asiEn(en[1]), .dataThroughEn(en[0]));

  rmpc_ctrl_model u_ctrl (.lockOut(lockOut),
    .lockOe(lockOe), .transOut(transOut), .transOe(transOe),
    .reqLock(reqLock), .reqTrans(reqTrans), .allowBoth(allowBoth),
    .lockWire(lockWire), .transWire(transWire));

  task automatic test_done;
    $display("Checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    q.push_back({a, e});
    @(posedge mclk);
    regRd <= 1'b0;
  endtask

  task automatic pins(input logic [1:0] p);
    @(posedge mclk);
    reqLock <= p[1];
    reqTrans <= p[0];
  endtask

  // Read data stand only in the cycle after the strobe.
  always @(negedge mclk)
  begin
    if (rdSeen === 1'b1)
    begin
      note = q.pop_front();
      cmp($sformatf("register %h", note.a), note.d, regRdata);
    end
    rdSeen = regRd;
  end

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  initial
  begin
    void'($urandom(3519));
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rd(OFS_CTRL, 32'h1);
    rd(OFS_IRQ_MASK, 32'h0);
    rd(OFS_IRQ_STAT, 32'h0);
    rd(8'h10, 32'h0);
    wr(OFS_MODE, 32'h0);
    rd(OFS_MODE, 32'h21);
    $display("Test reset and map done");
    pins(2'h1);
    lockedToStd <= 1'b1;
    waitc(4);
    @(negedge mclk);
    cmp("lock pin", 32'h3, 32'({lockOe, lockOut}));
    cmp("transport pin", 32'h2, 32'({transOe, transOut}));
    cmp("enables auto", 32'hC, 32'(en));
    rd(OFS_IRQ_STAT, 32'h2);
    wr(OFS_IRQ_MASK, 32'h2);
    @(negedge mclk);
    cmp("irq on", 32'h1, 32'(irq));
    wr(OFS_IRQ_STAT, 32'h2);
    @(negedge mclk);
    cmp("irq cleared", 32'h0, 32'(irq));
    $display("Test auto mode done");
    pins(2'h2);
    lockedToStd <= 1'b0;
    waitc(2);
    @(negedge mclk);
    cmp("lock pin low", 32'h2, 32'({lockOe, lockOut}));
    wr(OFS_CTRL, 32'h0);
    @(negedge mclk);
    cmp("pin release", 32'h0, 32'({lockOe, transOe}));
    waitc(4);
    for (int i = 0; i < 4; i++)
    begin
      allowBoth <= (i == 3);
      pins(pinTbl[i]);
      waitc(2);
      @(negedge mclk);
      cmp("enables early", 32'(enTbl[(i + 3) % 4]), 32'(en));
      waitc(1);
      @(negedge mclk);
      cmp("enables", 32'(enTbl[i]), 32'(en));
      rd(OFS_MODE, modeTbl[i]);
    end
    $display("Test manual modes done");
    allowBoth <= 1'b0;
    pins(2'h2);
    waitc(4);
    wr(OFS_IRQ_STAT, 32'h7);
    wr(OFS_IRQ_MASK, 32'h1);
    pins(2'h0);
    waitc(4);
    @(negedge mclk);
    cmp("irq mode", 32'h1, 32'(irq));
    rd(OFS_IRQ_STAT, 32'h1);
    wr(OFS_IRQ_MASK, 32'h0);
    @(negedge mclk);
    cmp("irq masked", 32'h0, 32'(irq));
    $display("Test interrupts done");
    for (int s = 0; s < 2; s++)
    begin
      waitc(1);
      styleSel <= s[0];
      waitc(4);
      repeat (4)
      begin
        @(posedge mclk);
        tIn <= 6'($urandom);
        waitc(2);
        @(negedge mclk);
        cmp("timing", 32'(s[0] ? tIn[2:0] : tIn[5:3]), 32'(timingOut));
      end
    end
    $display("Test timing style done");
    waitc(2);
    test_done();
  end
endmodule
`default_nettype wire
